// ===== vtcc_pkg.sv
// constants shared by the video timing core control register block
package vtcc_pkg;
  // ----------------------------------------------------------------
  // widths and offsets
  // ----------------------------------------------------------------
  localparam int          W        = 32;
  localparam int          AW       = 16;
  localparam int          LOCK_W   = 8;
  localparam int          POL_N    = 7;
  localparam int          HALF     = 16;
  localparam logic [15:0] CTRL_OFS = 16'h0000;
  // ----------------------------------------------------------------
  // control register bit positions
  // ----------------------------------------------------------------
  localparam int BIT_SW_RST = 31;
  localparam int BIT_FS_RST = 30;
  localparam int BIT_POL_LO = 20; // polarity selects 26..20
  localparam int BIT_CHROMA = 18;
  localparam int BIT_VBH    = 17;
  localparam int BIT_VS_END = 16;
  localparam int BIT_VS_BEG = 15;
  localparam int BIT_VIS_V  = 14;
  localparam int BIT_TOT_V  = 13;
  localparam int BIT_HS_END = 11;
  localparam int BIT_HS_BEG = 10;
  localparam int BIT_VIS_H  = 9;
  localparam int BIT_TOT_H  = 8;
  localparam int BIT_SYNC   = 5;
  localparam int BIT_DET    = 3;
  localparam int BIT_GEN    = 2;
  localparam int BIT_UPD    = 1;
  localparam int BIT_GLB    = 0;
  // writable storage bits, reset value, zero word
  localparam logic [W-1:0] CTRL_WMASK = 32'h07F7_EF2F;
  localparam logic [W-1:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [W-1:0] ZERO_W     = 32'h0000_0000;
  // ----------------------------------------------------------------
  // core reset length
  // ----------------------------------------------------------------
  localparam int          RST_NS  = 40;
  localparam int          CLK_MHZ = 100;
  localparam int          RST_INT = (RST_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  RST_CYC = 4'(RST_INT);
  localparam logic [3:0]  CNT_ONE = 4'h1;
  localparam logic [3:0]  CNT_0   = 4'h0;
  // deferred reset engine states
  typedef enum logic [1:0] {FS_IDLE, FS_WAIT, FS_RUN} vtcc_fs_t;
endpackage

// ===== vtcc_ctrl.sv
// control register, reset engine and source selects of the timing core
//
// Overview of operation
// - writing bit 31 resets core, self-clears
// - bit 30 resets after next frame start
// - bits 26..20 pick each polarity source
// - bit 18 picks encoding and chroma source
// - bit 17 picks field-0 blank offsets source
// - bit 16 picks field-0 sync end source
// - bit 15 picks field-0 sync start source
// - bit 14 picks visible lines source
// - bit 13 picks total lines source
// - bit 11 picks line sync end source
// - bit 10 picks line sync start source
// - bit 9 picks visible pixels source
// - bit 8 picks total pixels source
// - bit 5 lets generator synchronise
// - bit 3 turns detection on
// - detection off holds lock indications low
// - global enable runs detector and generator
// - detector enable is detect OR global
// - generator enable is generate OR global
// - bit 2 turns generation on
// - bit 1 commits shadow registers at frame
module vtcc_ctrl
  import vtcc_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic [vtcc_pkg::AW-1:0] reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [vtcc_pkg::W-1:0] reg_wdata,
  output logic      [vtcc_pkg::W-1:0] reg_rdata,
  output logic                       reg_rvalid,
  input  wire logic                  frame_start,
  input  wire logic [vtcc_pkg::LOCK_W-1:0] det_lock,
  input  wire logic [vtcc_pkg::W-1:0] meas_active_size,
  input  wire logic [vtcc_pkg::W-1:0] meas_encoding,
  input  wire logic [vtcc_pkg::W-1:0] meas_polarity,
  input  wire logic [vtcc_pkg::W-1:0] meas_hsize,
  input  wire logic [vtcc_pkg::W-1:0] meas_vsize,
  input  wire logic [vtcc_pkg::W-1:0] meas_line_sync,
  input  wire logic [vtcc_pkg::W-1:0] meas_blank_offset,
  input  wire logic [vtcc_pkg::W-1:0] meas_frame_sync_v,
  input  wire logic [vtcc_pkg::W-1:0] meas_frame_sync_h,
  input  wire logic [vtcc_pkg::W-1:0] prog_active_size,
  input  wire logic [vtcc_pkg::W-1:0] prog_encoding,
  input  wire logic [vtcc_pkg::W-1:0] prog_polarity,
  input  wire logic [vtcc_pkg::W-1:0] prog_hsize,
  input  wire logic [vtcc_pkg::W-1:0] prog_vsize,
  input  wire logic [vtcc_pkg::W-1:0] prog_line_sync,
  input  wire logic [vtcc_pkg::W-1:0] prog_blank_offset,
  input  wire logic [vtcc_pkg::W-1:0] prog_frame_sync_v,
  input  wire logic [vtcc_pkg::W-1:0] prog_frame_sync_h,
  output logic      [vtcc_pkg::W-1:0] gen_active_size,
  output logic      [vtcc_pkg::W-1:0] gen_encoding,
  output logic      [vtcc_pkg::W-1:0] gen_polarity,
  output logic      [vtcc_pkg::W-1:0] gen_hsize,
  output logic      [vtcc_pkg::W-1:0] gen_vsize,
  output logic      [vtcc_pkg::W-1:0] gen_line_sync,
  output logic      [vtcc_pkg::W-1:0] gen_blank_offset,
  output logic      [vtcc_pkg::W-1:0] gen_frame_sync_v,
  output logic      [vtcc_pkg::W-1:0] gen_frame_sync_h,
  output logic                       core_reset,
  output logic                       detection_on,
  output logic                       generation_on,
  output logic                       sync_enable,
  output logic                       regs_commit,
  output logic      [vtcc_pkg::LOCK_W-1:0] lock_out
);
  import vtcc_pkg::*;

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  logic [W-1:0] ctrl_reg;
  logic         sw_rst_reg;
  vtcc_fs_t     fs_reg;
  logic [3:0]   cnt_reg;
  logic [3:0]   cnt_next;
  logic         hit;
  logic         wr_ctrl;
  logic         wr31;
  logic         wr30;
  logic         fs_fire;
  logic         trig;
  logic         done;
  logic         busy;
  logic [W-1:0] ctrl_view;

  // decode of a control write
  assign hit     = (reg_addr == CTRL_OFS);
  assign wr_ctrl = ce && reg_wr && hit;
  assign wr31    = wr_ctrl && reg_wdata[BIT_SW_RST];
  assign wr30    = wr_ctrl && reg_wdata[BIT_FS_RST];

  // storage bits; reserved positions never stored
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= reg_wdata & CTRL_WMASK;
    end
  end

  // readback shows reset progress in the top two bits
  always_comb begin
    ctrl_view             = ctrl_reg;
    ctrl_view[BIT_SW_RST] = sw_rst_reg;
    ctrl_view[BIT_FS_RST] = (fs_reg != FS_IDLE);
  end

  // registered read answer, zero off the map
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata  <= ZERO_W;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd && hit) begin
        reg_rdata <= ctrl_view;
      end else begin
        reg_rdata <= ZERO_W;
      end
    end
  end

  // ----------------------------------------------------------------
  // reset engine
  // ----------------------------------------------------------------
  // deferred reset fires on the frame start after the request
  assign fs_fire = (fs_reg == FS_WAIT) && frame_start;
  assign trig    = ce && (wr31 || fs_fire);
  assign done    = ce && !trig && (cnt_reg == CNT_ONE);

  // reset length counter, reloaded by a new request
  always_comb begin
    if (trig) begin
      cnt_next = RST_CYC;
    end else if (ce && cnt_reg != CNT_0) begin
      cnt_next = cnt_reg - CNT_ONE;
    end else begin
      cnt_next = cnt_reg;
    end
  end
  assign busy = (cnt_next != CNT_0);

  // counter and core reset output
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_reg    <= CNT_0;
      core_reset <= 1'b0;
    end else if (ce) begin
      cnt_reg    <= cnt_next;
      core_reset <= busy;
    end
  end

  // immediate reset flag; a new write wins over completion
  always_ff @(posedge clock) begin
    if (rst) begin
      sw_rst_reg <= 1'b0;
    end else if (wr31) begin
      sw_rst_reg <= 1'b1;
    end else if (done) begin
      sw_rst_reg <= 1'b0;
    end
  end

  // deferred reset sequence
  always_ff @(posedge clock) begin
    if (rst) begin
      fs_reg <= FS_IDLE;
    end else if (ce) begin
      unique case (fs_reg)
        FS_IDLE: begin
          if (wr30) begin
            fs_reg <= FS_WAIT;
          end
        end
        FS_WAIT: begin
          if (frame_start) begin
            fs_reg <= FS_RUN;
          end
        end
        FS_RUN: begin
          if (wr30) begin
            fs_reg <= FS_WAIT;
          end else if (done) begin
            fs_reg <= FS_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // enables, lock and commit
  // ----------------------------------------------------------------
  logic det_on;
  logic gen_on;

  assign det_on = ctrl_reg[BIT_DET] || ctrl_reg[BIT_GLB];
  assign gen_on = ctrl_reg[BIT_GEN] || ctrl_reg[BIT_GLB];

  // detection and generation enables drop while the core is held in reset; sync_enable does not
  always_ff @(posedge clock) begin
    if (rst) begin
      detection_on  <= 1'b0;
      generation_on  <= 1'b0;
      sync_enable <= 1'b0;
      lock_out    <= '0;
      regs_commit <= 1'b0;
    end else if (ce) begin
      detection_on  <= det_on && !busy;
      generation_on  <= gen_on && !busy;
      sync_enable <= ctrl_reg[BIT_SYNC];
      lock_out    <= (det_on && !busy) ? det_lock : '0;
      regs_commit <= frame_start && ctrl_reg[BIT_UPD];
    end else begin
      regs_commit <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // source selects
  // ----------------------------------------------------------------
  // low and high halves chosen apart
  function automatic logic [W-1:0] pick(
    input logic         sel_lo,
    input logic         sel_hi,
    input logic [W-1:0] m,
    input logic [W-1:0] p
  );
    logic [W-1:0] r;
    r[HALF-1:0] = sel_lo ? p[HALF-1:0] : m[HALF-1:0];
    r[W-1:HALF] = sel_hi ? p[W-1:HALF] : m[W-1:HALF];
    return r;
  endfunction

  // each parameter follows its select bits; both frame sync words share bits 15 and 16
  always_ff @(posedge clock) begin
    if (rst) begin
      gen_active_size  <= ZERO_W;
      gen_encoding     <= ZERO_W;
      gen_hsize        <= ZERO_W;
      gen_vsize        <= ZERO_W;
      gen_line_sync    <= ZERO_W;
      gen_blank_offset <= ZERO_W;
      gen_frame_sync_v <= ZERO_W;
      gen_frame_sync_h <= ZERO_W;
    end else if (ce) begin
      gen_active_size  <= pick(ctrl_reg[BIT_VIS_H], ctrl_reg[BIT_VIS_V],
                               meas_active_size, prog_active_size);
      gen_encoding     <= pick(ctrl_reg[BIT_CHROMA], ctrl_reg[BIT_CHROMA],
                               meas_encoding, prog_encoding);
      gen_hsize        <= pick(ctrl_reg[BIT_TOT_H], ctrl_reg[BIT_TOT_H],
                               meas_hsize, prog_hsize);
      gen_vsize        <= pick(ctrl_reg[BIT_TOT_V], ctrl_reg[BIT_TOT_V],
                               meas_vsize, prog_vsize);
      gen_line_sync    <= pick(ctrl_reg[BIT_HS_BEG], ctrl_reg[BIT_HS_END],
                               meas_line_sync, prog_line_sync);
      gen_blank_offset <= pick(ctrl_reg[BIT_VBH], ctrl_reg[BIT_VBH],
                               meas_blank_offset, prog_blank_offset);
      gen_frame_sync_v <= pick(ctrl_reg[BIT_VS_BEG], ctrl_reg[BIT_VS_END],
                               meas_frame_sync_v, prog_frame_sync_v);
      gen_frame_sync_h <= pick(ctrl_reg[BIT_VS_BEG], ctrl_reg[BIT_VS_END],
                               meas_frame_sync_h, prog_frame_sync_h);
    end
  end

  // polarity bits one by one; unused high bits pass measured
  always_ff @(posedge clock) begin
    if (rst) begin
      gen_polarity <= ZERO_W;
    end else if (ce) begin
      gen_polarity <= meas_polarity;
      for (int i = 0; i < POL_N; i++) begin
        gen_polarity[i] <= ctrl_reg[BIT_POL_LO + i] ?
                           prog_polarity[i] : meas_polarity[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_sw_req;
    ce && wr31;
  endsequence

  sequence s_fs_fire;
    ce && fs_fire && !wr31;
  endsequence

  sequence s_commit;
    ce && frame_start && ctrl_reg[BIT_UPD];
  endsequence

  a_soft_core_reset_start: assert property (
    @(posedge clock) disable iff (rst)
    s_sw_req |=> core_reset && sw_rst_reg && cnt_reg == RST_CYC)
    else $error("soft reset did not start");

  a_soft_core_reset_end: assert property (
    @(posedge clock) disable iff (rst)
    (done && !wr31) |=> !sw_rst_reg && !core_reset)
    else $error("soft reset flag did not clear");

  a_fs_reset_fire: assert property (
    @(posedge clock) disable iff (rst)
    s_fs_fire |=> core_reset && fs_reg == FS_RUN)
    else $error("deferred reset missed frame start");

  a_fs_reset_wait: assert property (
    @(posedge clock) disable iff (rst)
    (ce && wr30 && !wr31 && cnt_reg == CNT_0 && fs_reg == FS_IDLE)
    |=> fs_reg == FS_WAIT && !core_reset)
    else $error("deferred reset acted early");

  a_pol_select: assert property (
    @(posedge clock) disable iff (rst)
    ce |=> gen_polarity[0] == ($past(ctrl_reg[BIT_POL_LO]) ?
           $past(prog_polarity[0]) : $past(meas_polarity[0])))
    else $error("blank polarity source wrong");

  a_encoding_src: assert property (
    @(posedge clock) disable iff (rst)
    (ce && !ctrl_reg[BIT_CHROMA]) |=> gen_encoding == $past(meas_encoding))
    else $error("encoding not from measured");

  a_visible_lines: assert property (
    @(posedge clock) disable iff (rst)
    (ce && ctrl_reg[BIT_VIS_V])
    |=> gen_active_size[W-1:HALF] == $past(prog_active_size[W-1:HALF]))
    else $error("visible lines not programmed");

  a_total_pixels: assert property (
    @(posedge clock) disable iff (rst)
    (ce && ctrl_reg[BIT_TOT_H]) |=> gen_hsize == $past(prog_hsize))
    else $error("total pixels not programmed");

  a_detection_on: assert property (
    @(posedge clock) disable iff (rst)
    ce |=> detection_on == ($past(det_on) && !core_reset))
    else $error("detector enable wrong");

  a_generation_on: assert property (
    @(posedge clock) disable iff (rst)
    (ce && ctrl_reg[BIT_GLB]) |=> generation_on || core_reset)
    else $error("global enable did not run generator");

  a_lock_low: assert property (
    @(posedge clock) disable iff (rst)
    (ce && !ctrl_reg[BIT_DET] && !ctrl_reg[BIT_GLB]) |=> lock_out == '0)
    else $error("lock shown with detection off");

  a_commit_pulse: assert property (
    @(posedge clock) disable iff (rst)
    s_commit |=> regs_commit ##1 (!regs_commit || $past(frame_start)))
    else $error("commit pulse wrong");

  a_reserved_zero: assert property (
    @(posedge clock) disable iff (rst)
    reg_rvalid |-> (reg_rdata[29:27] == 3'h0 && !reg_rdata[19] &&
                    !reg_rdata[12] && reg_rdata[7:6] == 2'h0 &&
                    !reg_rdata[4]))
    else $error("reserved bit read nonzero");

endmodule

// ===== vtcc_host_model.sv
// host processor model that drives the control register port
module vtcc_host_model
  import vtcc_pkg::*;
(
  input  wire logic                    clock,
  output logic      [vtcc_pkg::AW-1:0] reg_addr,
  output logic                         reg_wr,
  output logic                         reg_rd,
  output logic      [vtcc_pkg::W-1:0]  reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0000_0000;
  end
  // one-cycle write strobe, then lines show the inverse of the last value
  task automatic write(input logic [AW-1:0] a, input logic [W-1:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // one-cycle read strobe
  task automatic read(input logic [AW-1:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask
endmodule

// ===== tb_vtcc_ctrl.sv
// self-checking testbench for the timing core control register block
module tb_vtcc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import vtcc_pkg::*;
  localparam logic [31:0] RW = 32'h07F7_EF2F; // stored bits that read back as written
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  logic          ce = 1'b1;
  logic          frame_start = 1'b0;
  logic [7:0]    det_lock = 8'h00;
  logic [7:0]    lock_out;
  logic [W-1:0]  meas [9];
  logic [W-1:0]  prog [9];
  logic [W-1:0]  gen [9];
  logic [W-1:0]  reg_wdata, reg_rdata, c;
  logic [AW-1:0] reg_addr;
  logic          reg_wr, reg_rd, reg_rvalid, core_reset;
  logic          detection_on, generation_on, sync_enable, regs_commit;
  logic [W-1:0]  exp_q [$];
  int            err_total = 0, compares = 0, cyc = 0;
  int            run_len = 0, last_run = 0, commits = 0;

  always #5 clock = ~clock;

  vtcc_host_model u_vtcc_host_model (.clock(clock), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

  vtcc_ctrl u_vtcc_ctrl (
    .clock(clock), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .frame_start(frame_start), .det_lock(det_lock),
    .meas_active_size(meas[0]), .meas_encoding(meas[1]),
    .meas_polarity(meas[2]), .meas_hsize(meas[3]), .meas_vsize(meas[4]),
    .meas_line_sync(meas[5]), .meas_blank_offset(meas[6]),
    .meas_frame_sync_v(meas[7]), .meas_frame_sync_h(meas[8]),
    .prog_active_size(prog[0]), .prog_encoding(prog[1]),
    .prog_polarity(prog[2]), .prog_hsize(prog[3]), .prog_vsize(prog[4]),
    .prog_line_sync(prog[5]), .prog_blank_offset(prog[6]),
    .prog_frame_sync_v(prog[7]), .prog_frame_sync_h(prog[8]),
    .gen_active_size(gen[0]), .gen_encoding(gen[1]),
    .gen_polarity(gen[2]), .gen_hsize(gen[3]), .gen_vsize(gen[4]),
    .gen_line_sync(gen[5]), .gen_blank_offset(gen[6]),
    .gen_frame_sync_v(gen[7]), .gen_frame_sync_h(gen[8]),
    .core_reset(core_reset), .detection_on(detection_on),
    .generation_on(generation_on), .sync_enable(sync_enable),
    .regs_commit(regs_commit), .lock_out(lock_out));

  // compare one value and count it
  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // counts, verdict and end of run
  task automatic finish_test();
    $display("counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // register access wrappers; a read notes its expected word
  task automatic wr(input logic [W-1:0] d, input logic [AW-1:0] a = 16'h0000);
    u_vtcc_host_model.write(a, d);
  endtask
  task automatic rd(input logic [W-1:0] e, input logic [AW-1:0] a = 16'h0000);
    exp_q.push_back(e);
    u_vtcc_host_model.read(a);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic pulse_frame();
    @(posedge clock);
    frame_start <= 1'b1;
    @(posedge clock);
    frame_start <= 1'b0;
  endtask

  // half-word source pick
  function automatic logic [W-1:0] pk(input logic lo, input logic hi,
                                      input logic [W-1:0] m, p);
    return {hi ? p[31:16] : m[31:16], lo ? p[15:0] : m[15:0]};
  endfunction

  // expected generator word for output k under control word cw
  function automatic logic [W-1:0] exp_gen(input int k,
                                           input logic [W-1:0] cw);
    logic [W-1:0] m, p, r;
    m = meas[k];
    p = prog[k];
    case (k)
      0: r = pk(cw[9], cw[14], m, p);
      1: r = pk(cw[18], cw[18], m, p);
      2: begin
        r = m;
        for (int i = 0; i < 7; i++)
          r[i] = cw[20+i] ? p[i] : m[i];
      end
      3: r = pk(cw[8], cw[8], m, p);
      4: r = pk(cw[13], cw[13], m, p);
      5: r = pk(cw[10], cw[11], m, p);
      6: r = pk(cw[17], cw[17], m, p);
      default: r = pk(cw[15], cw[16], m, p);
    endcase
    return r;
  endfunction

  // monitor: reset run length, commits, read answers, timeout
  always @(posedge clock) begin
    cyc++;
    if (core_reset === 1'b1)
      run_len++;
    else if (run_len != 0) begin
      last_run = run_len;
      run_len = 0;
    end
    if (regs_commit === 1'b1)
      commits++;
    if (reg_rvalid === 1'b1)
      check(reg_rdata, exp_q.size() ? exp_q.pop_front() : {W{1'bx}});
    if (cyc == 3000) begin
      err_total++;
      $display("mismatch at %0t: timeout", $time);
      finish_test();
    end
  end

  // main sequence
  initial begin
    c = $urandom(11); // seed the generator once
    foreach (meas[k]) begin
      meas[k] = $urandom;
      prog[k] = 32'h0000_0000;
    end
    repeat (4) @(posedge clock);
    #1;
    for (int k = 0; k < 9; k++)
      check(gen[k], 32'h0000_0000);
    check({core_reset, detection_on, generation_on, lock_out}, 32'h0);
    @(posedge clock);
    rst <= 1'b0;
    rd(32'h0000_0000);
    $display("test reset done");
    // random selects over every enable combination
    for (int i = 0; i < 16; i++) begin
      @(posedge clock);
      foreach (meas[k]) begin
        meas[k] <= $urandom;
        prog[k] <= $urandom;
      end
      det_lock <= 8'($urandom);
      c = $urandom;
      c[31:30] = 2'b00;
      {c[5], c[3], c[2], c[0]} = 4'(i);
      wr(c);
      wait_cyc(3);
      for (int k = 0; k < 9; k++)
        check(gen[k], exp_gen(k, c));
      check(detection_on, c[3] | c[0]);
      check(generation_on, c[2] | c[0]);
      check(sync_enable, c[5]);
      check(lock_out, (c[3] | c[0]) ? det_lock : 8'h00);
      rd(c & RW);
    end
    $display("test selects done");
    // frozen clock enable, unmapped address
    @(posedge clock);
    ce <= 1'b0;
    wr(32'h0000_0020);
    ce <= 1'b1;
    rd(c & RW);
    wr(32'hFFFF_FFFF, 16'h0004);
    rd(c & RW);
    rd(32'h0000_0000, 16'h0004);
    $display("test register access done");
    // commit only with update bit set
    wr(32'h0000_0002);
    pulse_frame();
    wait_cyc(2);
    check(commits, 1);
    wr(32'h0000_0000);
    pulse_frame();
    wait_cyc(2);
    check(commits, 1);
    $display("test commit done");
    // deferred reset waits for a frame start
    wr(32'h4000_0009);
    last_run = 0;
    wait_cyc(4);
    check(core_reset, 1'b0);
    rd(32'h4000_0009);
    pulse_frame();
    wait_cyc(7);
    check(last_run, 4);
    rd(32'h0000_0009);
    $display("test deferred reset done");
    // immediate reset forces detection and generation enables and lock low
    det_lock <= 8'hA5;
    last_run = 0;
    wr(32'h8000_0009);
    rd(32'h8000_0009);
    #1;
    check({detection_on, generation_on, lock_out}, 32'h0);
    wait_cyc(6);
    check(last_run, 4);
    check(lock_out, 8'hA5);
    rd(32'h0000_0009);
    $display("test soft reset done");
    // synchronous reset in mid-run clears the register and enables
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    rd(32'h0000_0000);
    #1;
    check({detection_on, generation_on, sync_enable}, 32'h0);
    $display("test mid-run reset done");
    wait_cyc(4);
    finish_test();
  end
endmodule
